// ==== src/tcdet_top.sv ====
// Functional notes
// - single tap: above threshold, back below before time limit
// - still above at time limit expiry: no tap, no interrupt
// - unlatched: request held the latency interval after the last event, to within one tick
// - latched: request held until source register is read
// - request routable to pin a, pin b or both
// - double tap interrupt only after first and second tap
// - second tap detection suppressed during latency
// - second detection starts on crossing inside the window
// - second detection starts if still above at latency end
// - second tap must fall below before time limit
// - crossing after window expiry gives no double tap
// - timing independent of output data rate
// - config at 38h holds latch enable, reset 0
// - per axis single and double enables, reset 0
// - per axis enable pair selects none, single, double or both
// - 4-bit thresholds in 0.5g steps, reset 0000
// - 8-bit time limit in 0.5 ms units
// - 8-bit latency and window in 1 ms units
// - source register: per axis flags plus active flag
`timescale 1ns/1ns
`default_nettype none
module tcdet_top #(
  parameter int unsigned TICK_CYCLES = tcdet_pkg::TICK_CYCLES,
  parameter int unsigned ACC_W       = 8,
  parameter int unsigned THR_SHIFT   = 3
) (
  input  wire logic             MCLK_I,
  input  wire logic             RST_N_I,
  input  wire logic [7:0]       REG_ADDR_I,
  input  wire logic [7:0]       REG_WDATA_I,
  input  wire logic             REG_WR_I,
  input  wire logic             REG_RD_I,
  input  wire logic             SAMPLE_VALID_I,
  input  wire logic [ACC_W-1:0] ACC_X_I,
  input  wire logic [ACC_W-1:0] ACC_Y_I,
  input  wire logic [ACC_W-1:0] ACC_Z_I,
  input  wire logic             ROUTE_A_I,
  input  wire logic             ROUTE_B_I,
  output logic [7:0]            REG_RDATA_O,
  output logic                  IRQ_PIN_A_O,
  output logic                  IRQ_PIN_B_O
);
  localparam int unsigned TB_W = $clog2(TICK_CYCLES + 1);

  logic [7:0]                  tap_detect_config_ff;
  logic [7:0]                  thr_xy_ff;
  logic [tcdet_pkg::THR_W-1:0] z_threshold_ff;
  logic [7:0]                  tap_time_limit_ff;
  logic [7:0]                  latency_ff;
  logic [7:0]                  window_ff;
  logic [TB_W-1:0]             tb_ff;
  logic                        tick_ff;
  logic [tcdet_pkg::EV_W-1:0]  src_ff;
  logic [tcdet_pkg::EV_W-1:0]  ev;
  logic [tcdet_pkg::EV_W-1:0]  nxt_src;
  logic [tcdet_pkg::CNT_W-1:0] hold_ff;
  logic                        hold_act_ff;
  logic                        hold_end;
  logic                        nxt_req;
  logic                        src_rd;
  logic [ACC_W-1:0]            acc [tcdet_pkg::NUM_AXES];
  logic [tcdet_pkg::THR_W-1:0] thr [tcdet_pkg::NUM_AXES];
  logic                        above_ff [tcdet_pkg::NUM_AXES];
  logic                        latch_request_enable;

  assign latch_request_enable = tap_detect_config_ff[tcdet_pkg::BIT_LIR];
  assign acc[0] = ACC_X_I;
  assign acc[1] = ACC_Y_I;
  assign acc[2] = ACC_Z_I;
  assign thr[0] = thr_xy_ff[tcdet_pkg::THR_Y_LSB-1:0];
  assign thr[1] = thr_xy_ff[tcdet_pkg::THR_Y_LSB+tcdet_pkg::THR_W-1:tcdet_pkg::THR_Y_LSB];
  assign thr[2] = z_threshold_ff;
  assign src_rd = REG_RD_I && (REG_ADDR_I == tcdet_pkg::OFS_SRC);

  ////////////////////////////////////////////////////////////////////////////
  // register writes
  // config with latch bit
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tap_detect_config_ff <= tcdet_pkg::CFG_RST;
      thr_xy_ff            <= {2{tcdet_pkg::THR_RST}};
      z_threshold_ff       <= tcdet_pkg::THR_RST;
      tap_time_limit_ff    <= tcdet_pkg::TIME_RST;
      latency_ff           <= tcdet_pkg::TIME_RST;
      window_ff            <= tcdet_pkg::TIME_RST;
    end else if (REG_WR_I) begin
      if (REG_ADDR_I == tcdet_pkg::OFS_CFG) begin
        tap_detect_config_ff <= REG_WDATA_I;
      end else if (REG_ADDR_I == tcdet_pkg::OFS_THR_XY) begin
        thr_xy_ff <= REG_WDATA_I;
      end else if (REG_ADDR_I == tcdet_pkg::OFS_THR_Z) begin
        z_threshold_ff <= REG_WDATA_I[tcdet_pkg::THR_W-1:0];
      end else if (REG_ADDR_I == tcdet_pkg::OFS_TLIM) begin
        tap_time_limit_ff <= REG_WDATA_I;
      end else if (REG_ADDR_I == tcdet_pkg::OFS_LAT) begin
        latency_ff <= REG_WDATA_I;
      end else if (REG_ADDR_I == tcdet_pkg::OFS_WIN) begin
        window_ff <= REG_WDATA_I;
      end
    end
  end

  // read data; source register read also clears it below
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      REG_RDATA_O <= tcdet_pkg::RD_ZERO;
    end else if (REG_RD_I) begin
      if (REG_ADDR_I == tcdet_pkg::OFS_CFG) begin
        REG_RDATA_O <= tap_detect_config_ff;
      end else if (REG_ADDR_I == tcdet_pkg::OFS_SRC) begin
        REG_RDATA_O <= {1'b0, |src_ff, src_ff};
      end else if (REG_ADDR_I == tcdet_pkg::OFS_THR_XY) begin
        REG_RDATA_O <= thr_xy_ff;
      end else if (REG_ADDR_I == tcdet_pkg::OFS_THR_Z) begin
        REG_RDATA_O <= {{(8-tcdet_pkg::THR_W){1'b0}}, z_threshold_ff};
      end else if (REG_ADDR_I == tcdet_pkg::OFS_TLIM) begin
        REG_RDATA_O <= tap_time_limit_ff;
      end else if (REG_ADDR_I == tcdet_pkg::OFS_LAT) begin
        REG_RDATA_O <= latency_ff;
      end else if (REG_ADDR_I == tcdet_pkg::OFS_WIN) begin
        REG_RDATA_O <= window_ff;
      end else begin
        REG_RDATA_O <= tcdet_pkg::RD_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fixed time base, not tied to the sample rate
  // half ms tick
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      tb_ff   <= '0;
      tick_ff <= 1'b0;
    end else if (tb_ff == TB_W'(TICK_CYCLES - 1)) begin
      tb_ff   <= '0;
      tick_ff <= 1'b1;
    end else begin
      tb_ff   <= tb_ff + 1'b1;
      tick_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per axis magnitude compare and detector
  for (genvar g = 0; g < tcdet_pkg::NUM_AXES; g++) begin : g_axis
    logic [ACC_W-1:0] mag;
    assign mag = acc[g][ACC_W-1] ? ACC_W'(-acc[g]) : acc[g];

    // level held between samples
    // threshold compare
    always_ff @(posedge MCLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
        above_ff[g] <= 1'b0;
      end else if (SAMPLE_VALID_I) begin
        above_ff[g] <= (thr[g] != tcdet_pkg::THR_RST) &&
                       (mag > (ACC_W'(thr[g]) << THR_SHIFT));
      end
    end

    tcdet_axis u_axis (
      .clk_i    (MCLK_I),
      .rst_n_i  (RST_N_I),
      .tick_i   (tick_ff),
      .above_i  (above_ff[g]),
      .sgl_en_i (tap_detect_config_ff[2*g]),
      .dbl_en_i (tap_detect_config_ff[2*g+1]),
      .tlim_i   (tap_time_limit_ff),
      .lat_i    (latency_ff),
      .win_i    (window_ff),
      .single_o (ev[2*g]),
      .double_o (ev[2*g+1])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // unlatched hold timer, reloaded by every event
  // hold for latency
  assign hold_end = hold_act_ff && (hold_ff == '0) && !(|ev);
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hold_ff     <= '0;
      hold_act_ff <= 1'b0;
    end else if (|ev) begin
      hold_ff     <= {latency_ff, 1'b0};
      hold_act_ff <= 1'b1;
    end else if (hold_end) begin
      hold_act_ff <= 1'b0;
    end else if (tick_ff && (hold_ff != '0)) begin
      hold_ff <= hold_ff - 1'b1;
    end
  end

  // new events win over a read clear
  // source flags
  always_comb begin
    nxt_src = src_ff;
    if (src_rd || (!latch_request_enable && hold_end)) begin
      nxt_src = '0;
    end
    nxt_src = nxt_src | ev;
  end

  assign nxt_req = latch_request_enable ? (|nxt_src) : (hold_act_ff && !hold_end) || (|ev);

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      src_ff <= '0;
    end else begin
      src_ff <= nxt_src;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      IRQ_PIN_A_O <= 1'b0;
      IRQ_PIN_B_O <= 1'b0;
    end else begin
      IRQ_PIN_A_O <= nxt_req && ROUTE_A_I;
      IRQ_PIN_B_O <= nxt_req && ROUTE_B_I;
    end
  end
endmodule
`default_nettype wire

// ==== src/tcdet_pkg.sv ====
package tcdet_pkg;
  // register offsets
  localparam logic [7:0] OFS_CFG    = 8'h38;
  localparam logic [7:0] OFS_SRC    = 8'h39;
  localparam logic [7:0] OFS_THR_XY = 8'h3b;
  localparam logic [7:0] OFS_THR_Z  = 8'h3c;
  localparam logic [7:0] OFS_TLIM   = 8'h3d;
  localparam logic [7:0] OFS_LAT    = 8'h3e;
  localparam logic [7:0] OFS_WIN    = 8'h3f;

  // field positions
  localparam int unsigned BIT_LIR   = 6;
  localparam int unsigned BIT_IA    = 6;
  localparam int unsigned EV_W      = 6;
  localparam int unsigned THR_W     = 4;
  localparam int unsigned THR_Y_LSB = 4;
  localparam int unsigned NUM_AXES  = 3;

  // reset values
  localparam logic [7:0]       CFG_RST  = 8'h00;
  localparam logic [THR_W-1:0] THR_RST  = 4'h0;
  localparam logic [7:0]       TIME_RST = 8'h00;
  localparam logic [7:0]       RD_ZERO  = 8'h00;

  // time base: one tick per 0.5 ms, latency and window count 1 ms units
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TICK_NS       = 500000;
  localparam int unsigned TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned CNT_W         = 9;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FIRST  = 3'b001,
    ST_LAT    = 3'b010,
    ST_WIN    = 3'b011,
    ST_SECOND = 3'b100,
    ST_LOW    = 3'b101
  } tcdet_state_t;
endpackage

// ==== src/tcdet_axis.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcdet_axis (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       tick_i,
  input  wire logic       above_i,
  input  wire logic       sgl_en_i,
  input  wire logic       dbl_en_i,
  input  wire logic [7:0] tlim_i,
  input  wire logic [7:0] lat_i,
  input  wire logic [7:0] win_i,
  output logic            single_o,
  output logic            double_o
);
  tcdet_pkg::tcdet_state_t                state_ff;
  tcdet_pkg::tcdet_state_t                nxt_state;
  logic [tcdet_pkg::CNT_W-1:0]            cnt_ff;
  logic                                   tlim_out;
  logic                                   lat_out;
  logic                                   win_out;
  logic                                   nxt_single;
  logic                                   nxt_double;

  // tick based counts, so the data rate never enters
  // rate independent timing
  assign tlim_out = cnt_ff >= {1'b0, tlim_i};
  assign lat_out  = cnt_ff >= {lat_i, 1'b0};
  assign win_out  = cnt_ff >= {win_i, 1'b0};

  always_comb begin
    nxt_state  = state_ff;
    nxt_single = 1'b0;
    nxt_double = 1'b0;
    case (state_ff)
      tcdet_pkg::ST_IDLE: begin
        if (above_i && (sgl_en_i || dbl_en_i)) begin
          nxt_state = tcdet_pkg::ST_FIRST;
        end
      end
      tcdet_pkg::ST_FIRST: begin
        if (!above_i && !tlim_out) begin
          nxt_single = sgl_en_i;
          nxt_state  = dbl_en_i ? tcdet_pkg::ST_LAT : tcdet_pkg::ST_IDLE;
        end else if (tlim_out) begin
          nxt_state = tcdet_pkg::ST_LOW;
        end
      end
      tcdet_pkg::ST_LAT: begin
        if (lat_out) begin
          nxt_state = above_i ? tcdet_pkg::ST_SECOND : tcdet_pkg::ST_WIN;
        end
      end
      tcdet_pkg::ST_WIN: begin
        if (above_i && !win_out) begin
          nxt_state = tcdet_pkg::ST_SECOND;
        end else if (win_out) begin
          nxt_state = above_i ? tcdet_pkg::ST_LOW : tcdet_pkg::ST_IDLE;
        end
      end
      tcdet_pkg::ST_SECOND: begin
        if (!above_i && !tlim_out) begin
          nxt_double = dbl_en_i;
          nxt_state  = tcdet_pkg::ST_IDLE;
        end else if (tlim_out) begin
          nxt_state = tcdet_pkg::ST_LOW;
        end
      end
      tcdet_pkg::ST_LOW: begin
        // a long push must end before a new tap starts
        if (!above_i) begin
          nxt_state = tcdet_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = tcdet_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= tcdet_pkg::ST_IDLE;
      single_o <= 1'b0;
      double_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      single_o <= nxt_single;
      double_o <= nxt_double;
    end
  end

  // restarts on every state change
  // half ms counter
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
    end else if (nxt_state != state_ff) begin
      cnt_ff <= '0;
    end else if (tick_i && !(&cnt_ff)) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end
endmodule
`default_nettype wire

// ==== verification/tcdet_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcdet_monitor #(
  parameter int unsigned ACC_W = 8
) (
  input wire logic             MCLK_I,
  input wire logic             RST_N_I,
  input wire logic [7:0]       REG_ADDR_I,
  input wire logic [7:0]       REG_WDATA_I,
  input wire logic             REG_WR_I,
  input wire logic             REG_RD_I,
  input wire logic             SAMPLE_VALID_I,
  input wire logic [ACC_W-1:0] ACC_X_I,
  input wire logic [ACC_W-1:0] ACC_Y_I,
  input wire logic [ACC_W-1:0] ACC_Z_I,
  input wire logic             ROUTE_A_I,
  input wire logic             ROUTE_B_I,
  input wire logic [7:0]       REG_RDATA_O,
  input wire logic             IRQ_PIN_A_O,
  input wire logic             IRQ_PIN_B_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  ////////////////////////////////////////////////////////////////
  sequence wr_s;
    REG_WR_I && REG_ADDR_I inside {8'h38, 8'h3b, 8'h3d, 8'h3e, 8'h3f};
  endsequence
  sequence rd_same_s;
    REG_RD_I && !REG_WR_I && REG_ADDR_I == $past(REG_ADDR_I, 2);
  endsequence
  wr_rd_match_a: assert property (wr_s ##2 rd_same_s |=> REG_RDATA_O == $past(REG_WDATA_I, 3))
    else $error("register readback differs from write");
  route_a_gate_a: assert property (!ROUTE_A_I && $past(!ROUTE_A_I) |-> !IRQ_PIN_A_O)
    else $error("pin a high while not routed");
  route_b_gate_a: assert property (!ROUTE_B_I && $past(!ROUTE_B_I) |-> !IRQ_PIN_B_O)
    else $error("pin b high while not routed");
  pins_agree_a: assert property (ROUTE_A_I && ROUTE_B_I && $past(ROUTE_A_I) && $past(ROUTE_B_I)
                                 |-> IRQ_PIN_A_O == IRQ_PIN_B_O)
    else $error("pins differ with both routes on");
  unmapped_zero_a: assert property (REG_RD_I && REG_ADDR_I == 8'h00 |=> REG_RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("read data moved without a read");
  src_active_a: assert property (REG_RD_I && REG_ADDR_I == 8'h39
                                 |=> REG_RDATA_O[6] == |REG_RDATA_O[5:0] && !REG_RDATA_O[7])
    else $error("active flag not the or of event flags");
  thr_z_top_a: assert property (REG_RD_I && REG_ADDR_I == 8'h3c |=> REG_RDATA_O[7:4] == 4'h0)
    else $error("upper z threshold bits not zero");
endmodule
bind tcdet_top tcdet_monitor #(.ACC_W(ACC_W)) u_tcdet_monitor (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .SAMPLE_VALID_I(SAMPLE_VALID_I), .ACC_X_I(ACC_X_I), .ACC_Y_I(ACC_Y_I), .ACC_Z_I(ACC_Z_I),
  .ROUTE_A_I(ROUTE_A_I), .ROUTE_B_I(ROUTE_B_I), .REG_RDATA_O(REG_RDATA_O),
  .IRQ_PIN_A_O(IRQ_PIN_A_O), .IRQ_PIN_B_O(IRQ_PIN_B_O));
`default_nettype wire

// ==== verification/tcdet_sensor_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module tcdet_sensor_model (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] above_i,
  output logic            valid_o,
  output logic [7:0]      acc_x_o,
  output logic [7:0]      acc_y_o,
  output logic [7:0]      acc_z_o
);
  // one sample every second cycle; y swings negative to exercise magnitude
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_o <= 1'b0;
      acc_x_o <= 8'h00;
      acc_y_o <= 8'h00;
      acc_z_o <= 8'h00;
    end else begin
      valid_o <= ~valid_o;
      acc_x_o <= above_i[0] ? 8'h28 : 8'h02;
      acc_y_o <= above_i[1] ? 8'hd8 : 8'hfe;
      acc_z_o <= above_i[2] ? 8'h28 : 8'h02;
    end
  end
endmodule
`default_nettype wire

// ==== verification/tap_click_detector_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module tap_click_detector_tb;
  `define CHK(nm, ex, got) begin \
    samples_checked++; \
    if ((got) !== (ex)) begin \
      error_cnt++; \
      $display("ERROR %s exp %h got %h", nm, ex, got); \
    end \
  end
  logic       clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, route_a = 1'b0, route_b = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, ax, ay, az;
  logic [2:0] above = 3'b000;
  logic       svalid, pin_a, pin_b;
  int         error_cnt = 0, samples_checked = 0, cycles = 0;
  always #4 clk = ~clk;
  tcdet_top #(.TICK_CYCLES(4)) u_tcdet_top (.MCLK_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .SAMPLE_VALID_I(svalid), .ACC_X_I(ax),
    .ACC_Y_I(ay), .ACC_Z_I(az), .ROUTE_A_I(route_a), .ROUTE_B_I(route_b), .REG_RDATA_O(rdata),
    .IRQ_PIN_A_O(pin_a), .IRQ_PIN_B_O(pin_b));
  tcdet_sensor_model u_tcdet_sensor_model (.clk_i(clk), .rst_n_i(rst_n), .above_i(above),
    .valid_o(svalid), .acc_x_o(ax), .acc_y_o(ay), .acc_z_o(az));
  ////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ceiling well above the roughly 1200 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      error_cnt++;
      summarize();
    end
  end
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK("rdata", e, rdata)
    @(posedge clk);
  endtask
  task automatic tap(input int i, input int len);
    above[i] <= 1'b1;
    repeat (len) @(posedge clk);
    above[i] <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_hi(input int lim);
    int n;
    n = 0;
    while ((pin_a | pin_b) !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] ofs [8] = '{8'h38, 8'h39, 8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h00};
    foreach (ofs[i]) rd_chk(ofs[i], 8'h00);
    wr_reg(8'h39, 8'hff);
    rd_chk(8'h39, 8'h00);
    wr_reg(8'h3c, 8'hff);
    rd_chk(8'h3c, 8'h0f);
    wr_reg(8'h00, 8'hff);
    rd_chk(8'h00, 8'h00);
  endtask
  task automatic t_setup;
    logic [7:0] a [5] = '{8'h3b, 8'h3c, 8'h3d, 8'h3e, 8'h3f};
    logic [7:0] d [5] = '{8'h11, 8'h01, 8'h10, 8'h02, 8'h04};
    foreach (a[i]) begin
      wr_reg(a[i], d[i]);
      rd_chk(a[i], d[i]);
    end
  endtask
  task automatic t_single;
    int n;
    wr_reg(8'h38, 8'h04);
    tap(1, 20);
    wait_hi(20);
    `CHK("pin_b_rise", 1'b1, pin_b)
    n = 0;
    while (pin_b === 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    // lat 2 ms = 4 ticks of 4 cycles, first tick may be short
    `CHK("hold_len", 1'b1, n >= 12 && n <= 18)
    rd_chk(8'h39, 8'h00);
  endtask
  task automatic t_long;
    tap(1, 100);
    wait_hi(60);
    `CHK("long_excursion", 1'b0, pin_b)
    wr_reg(8'h38, 8'h08);
    tap(1, 20);
    wait_hi(100);
    `CHK("double_only", 1'b0, pin_b)
  endtask
  task automatic t_axes;
    logic [7:0] b;
    route_a <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      b = 8'h01 << (2 * i);
      // both enables: the tap on the other axis is ignored, single shows on the own axis tap, double never follows
      wr_reg(8'h38, 8'h40 | b | (b << 1));
      tap((i + 1) % 3, 20);
      tap(i, 20);
      repeat (40) @(posedge clk);
      `CHK("pins_held", 2'b11, {pin_a, pin_b})
      rd_chk(8'h39, 8'h40 | b);
      `CHK("pin_a_release", 1'b0, pin_a)
    end
    route_b <= 1'b0;
  endtask
  // double tap with chosen gap and second length, latched
  task automatic dbl(input int gap, input int len2, input logic [7:0] e);
    wr_reg(8'h38, 8'h48);
    tap(1, 20);
    repeat (gap) @(posedge clk);
    tap(1, len2);
    repeat (60) @(posedge clk);
    rd_chk(8'h39, e);
  endtask
  task automatic t_dbl_window;
    dbl(26, 20, 8'h48);
  endtask
  task automatic t_dbl_latency;
    dbl(4, 4, 8'h00);
  endtask
  task automatic t_dbl_still_above;
    dbl(2, 34, 8'h48);
  endtask
  task automatic t_dbl_late;
    dbl(70, 20, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_setup();
    t_single();
    t_long();
    t_axes();
    t_dbl_window();
    t_dbl_latency();
    t_dbl_still_above();
    t_dbl_late();
    summarize();
  end
endmodule
`default_nettype wire
